// [card_host_port.sv]
// Host controller driving a removable card socket in memory, I/O or task-file mode
`timescale 1ns/1ps
module card_host_port (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	// AXI4-Lite register port
	input  wire logic [7:0]  i_awaddr,
	input  wire logic        i_awvalid,
	output logic             o_awready,
	input  wire logic [31:0] i_wdata,
	input  wire logic [3:0]  i_wstrb,
	input  wire logic        i_wvalid,
	output logic             o_wready,
	output logic [1:0]       o_bresp,
	output logic             o_bvalid,
	input  wire logic        i_bready,
	input  wire logic [7:0]  i_araddr,
	input  wire logic        i_arvalid,
	output logic             o_arready,
	output logic [31:0]      o_rdata,
	output logic [1:0]       o_rresp,
	output logic             o_rvalid,
	input  wire logic        i_rready,
	output logic             o_irq,
	// Socket pins
	output logic [10:0]      o_addr,
	output logic             o_card_enable_n,
	output logic             o_card_enable_odd_n,
	output logic             o_oe_n,
	output logic             o_we_n,
	output logic             o_iord_n,
	output logic             o_iowr_n,
	output logic             o_reg_n,
	output logic             o_card_reset,
	output logic             o_cable_select_n,
	output logic             o_cable_select_oe,
	output logic [15:0]      o_data,
	output logic [1:0]       o_data_oe,
	input  wire logic [15:0] i_data,
	input  wire logic        i_ready_irq,
	input  wire logic        i_wait_n,
	input  wire logic        i_battery_detect_second,
	input  wire logic        i_shared_status,
	output logic             o_pass_diagnostic_n,
	output logic             o_pass_diagnostic_oe
);
	import card_host_pkg::*;

	logic [1:0]           rst_sync_r;
	logic                 rst_n;
	logic [CTL_BITS-1:0]  ctrl_r;
	logic [10:0]          addr_r;
	logic [15:0]          wdata_r;
	logic                 cyc_write_r, cyc_io_r;
	logic [EV_BITS-1:0]   istat_r, imask_r, ev_set;
	logic                 aw_got_r, w_got_r;
	logic [7:0]           awaddr_r;
	logic [31:0]          wbuf_r;
	logic [3:0]           wstrb_r;
	logic                 wr_do, start;
	logic                 sel, strobe, busy, done;
	logic [15:0]          rdata;
	logic                 tf, io_mode, dma_on, wide, task_file_select_n, control_block_select_n;
	logic                 status_changed_n, status_changed_n_r, cirq_r, card_irq;
	logic [31:0]          rd_mux;
	logic                 rd_hit;

	// Reset release through two flops
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) rst_sync_r <= 2'b00;
		else rst_sync_r <= {rst_sync_r[0], 1'b1};
	end
	assign rst_n = rst_sync_r[1];

	// Write channel capture; address and data may come in either order
	assign o_awready = !aw_got_r && !o_bvalid;
	assign o_wready  = !w_got_r && !o_bvalid;
	assign wr_do     = aw_got_r && w_got_r;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_got_r <= 1'b0;
			w_got_r  <= 1'b0;
			awaddr_r <= 8'h00;
			wbuf_r   <= 32'h0000_0000;
			wstrb_r  <= 4'h0;
			o_bvalid <= 1'b0;
			o_bresp  <= RESP_OKAY;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_got_r <= 1'b1;
				awaddr_r <= i_awaddr;
			end
			if (i_wvalid && o_wready) begin
				w_got_r <= 1'b1;
				wbuf_r  <= i_wdata;
				wstrb_r <= i_wstrb; // Kept with the data; the master may drop strobes once taken
			end
			if (wr_do) begin
				aw_got_r <= 1'b0;
				w_got_r  <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp  <= (awaddr_r[7:2] <= OFS_IMASK[7:2] && awaddr_r != OFS_RDATA
					&& awaddr_r != OFS_STATUS && awaddr_r[1:0] == 2'b00) ? RESP_OKAY : RESP_SLV;
			end else if (o_bvalid && i_bready) o_bvalid <= 1'b0;
		end
	end

	// Control, address and data registers; only the low byte lanes are used
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_r  <= CTRL_RST;
			addr_r  <= 11'h000;
			wdata_r <= 16'h0000;
			imask_r <= 4'h0;
		end else if (wr_do) begin
			case (awaddr_r)
				OFS_CTRL: begin
					if (wstrb_r[0] || wstrb_r[1]) ctrl_r <= wbuf_r[CTL_BITS-1:0];
				end
				OFS_ADDR:  addr_r  <= wbuf_r[10:0];
				OFS_WDATA: wdata_r <= wbuf_r[15:0];
				OFS_IMASK: imask_r <= wbuf_r[EV_BITS-1:0];
				default: ;
			endcase
		end
	end

	// Command accepted only when the engine is idle; otherwise ignored
	assign start = wr_do && awaddr_r == OFS_CMD && wbuf_r[CMD_GO] && !busy;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			cyc_write_r <= 1'b0;
			cyc_io_r    <= 1'b0;
		end else if (start) begin
			cyc_write_r <= wbuf_r[CMD_WRITE];
			cyc_io_r    <= wbuf_r[CMD_IO] || tf; // Task file is always reached by I/O strobes
		end
	end

	card_cycle_engine i_card_cycle_engine (
		.i_clk    (i_clk),
		.i_rstn   (rst_n),
		.i_start  (start),
		.i_wait_n (i_wait_n),
		.i_data   (i_data),
		.o_select (sel),
		.o_strobe (strobe),
		.o_busy   (busy),
		.o_done   (done),
		.o_rdata  (rdata)
	);

	// Mode-dependent pin routing
	assign tf      = ctrl_r[CTL_MODE+:2] == MODE_TF;
	assign io_mode = ctrl_r[CTL_MODE+:2] == MODE_IO;
	assign dma_on  = tf && ctrl_r[CTL_DMA];
	assign wide    = ctrl_r[CTL_WIDE] || dma_on;
	assign task_file_select_n     = !(sel && !dma_on && !ctrl_r[CTL_CBLK]);
	assign control_block_select_n = !(sel && !dma_on && ctrl_r[CTL_CBLK]);
	assign o_addr = tf ? {8'h00, addr_r[2:0]} : addr_r;
	assign o_card_enable_n     = tf ? task_file_select_n : !sel;
	assign o_card_enable_odd_n = tf ? control_block_select_n : !(sel && wide);
	assign o_oe_n   = tf ? 1'b0 : !(strobe && !cyc_write_r && !cyc_io_r); // Low selects task-file mode
	assign o_we_n   = tf ? 1'b1 : !(strobe && cyc_write_r && !cyc_io_r);
	assign o_iord_n = !(strobe && !cyc_write_r && cyc_io_r);
	assign o_iowr_n = !(strobe && cyc_write_r && cyc_io_r);
	assign o_reg_n  = tf ? !dma_on : !ctrl_r[CTL_ATTR];
	assign o_card_reset = tf ? !ctrl_r[CTL_RESET] : ctrl_r[CTL_RESET];
	// Master pulls cable select low, slave leaves it open; card modes drive A25 level
	assign o_cable_select_n  = tf ? 1'b0 : ctrl_r[CTL_CABLE_SELECT_N];
	assign o_cable_select_oe = tf ? !ctrl_r[CTL_CABLE_SELECT_N] : 1'b1;
	assign o_pass_diagnostic_n  = 1'b0;
	assign o_pass_diagnostic_oe = tf && ctrl_r[CTL_PASS_DIAGNOSTIC_N];
	assign status_changed_n = i_shared_status;
	assign card_irq = io_mode ? !i_ready_irq : (tf && i_ready_irq);

	// Data pins come from a register; upper byte stays off on an 8-bit bus
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_data    <= 16'h0000;
			o_data_oe <= 2'b00;
		end else begin
			o_data    <= wdata_r;
			o_data_oe <= {start ? wbuf_r[CMD_WRITE] && wide : o_data_oe[1] && busy,
				start ? wbuf_r[CMD_WRITE] : o_data_oe[0] && busy};
		end
	end

	// Event detection on live pins, edges found against the sample registered the cycle before
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			status_changed_n_r <= 1'b1;
			cirq_r   <= 1'b0;
		end else begin
			status_changed_n_r <= status_changed_n;
			cirq_r   <= card_irq;
		end
	end
	assign ev_set[EV_DONE]    = done;
	assign ev_set[EV_STATUS_CHANGED_N]  = io_mode && ctrl_r[CTL_STSEN] && status_changed_n_r && !status_changed_n;
	assign ev_set[EV_CARDIRQ] = card_irq && !cirq_r;
	// Both battery lines must read high in memory mode
	assign ev_set[EV_BATT]    = ctrl_r[CTL_MODE+:2] == MODE_MEM && !(i_shared_status && i_battery_detect_second);

	// Sticky status, write one to clear; a new event wins over its clear
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) istat_r <= 4'h0;
		else if (wr_do && awaddr_r == OFS_ISTAT) istat_r <= (istat_r & ~wbuf_r[EV_BITS-1:0]) | ev_set;
		else istat_r <= istat_r | ev_set;
	end
	assign o_irq = |(istat_r & imask_r);

	// Read mux
	always_comb begin
		rd_mux = 32'h0000_0000;
		rd_hit = 1'b1;
		case (i_araddr)
			OFS_CTRL:   rd_mux[CTL_BITS-1:0] = ctrl_r;
			OFS_ADDR:   rd_mux[10:0] = addr_r;
			OFS_WDATA:  rd_mux[15:0] = wdata_r;
			OFS_RDATA:  rd_mux[15:0] = rdata;
			OFS_STATUS: rd_mux[5:0] = {tf && !ctrl_r[CTL_CABLE_SELECT_N], i_wait_n, i_battery_detect_second,
				i_shared_status, i_ready_irq, busy};
			OFS_ISTAT:  rd_mux[EV_BITS-1:0] = istat_r;
			OFS_IMASK:  rd_mux[EV_BITS-1:0] = imask_r;
			OFS_CMD:    rd_mux = 32'h0000_0000;
			default:    rd_hit = 1'b0;
		endcase
	end

	// Read channel; one read outstanding, answer the cycle after the address
	assign o_arready = !o_rvalid;
	always_ff @(posedge i_clk or negedge rst_n) begin
		if (!rst_n) begin
			o_rvalid <= 1'b0;
			o_rdata  <= 32'h0000_0000;
			o_rresp  <= RESP_OKAY;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rdata  <= rd_mux;
			o_rresp  <= rd_hit ? RESP_OKAY : RESP_SLV;
		end else if (o_rvalid && i_rready) o_rvalid <= 1'b0;
	end

	AST_TF_ADDR_LOW: assert property (@(posedge i_clk) disable iff (!rst_n)
		tf |-> o_addr[10:3] == 8'h00 && o_addr[2:0] == addr_r[2:0]) else $error("Upper address not low");
	AST_DMA_ACKNOWLEDGE_N_HIGH: assert property (@(posedge i_clk) disable iff (!rst_n)
		tf && !ctrl_r[CTL_DMA] |-> o_reg_n) else $error("DMA acknowledge asserted without DMA");
	AST_DMA_NO_CS: assert property (@(posedge i_clk) disable iff (!rst_n)
		tf && !o_reg_n |-> o_card_enable_n && o_card_enable_odd_n) else $error("Select active during DMA");
	AST_BYTE_LANE: assert property (@(posedge i_clk) disable iff (!rst_n)
		!tf && !ctrl_r[CTL_WIDE] |-> o_card_enable_odd_n && !o_data_oe[1]) else $error("Upper byte used on 8-bit");
	AST_CABLE_SELECT_N_DRIVE: assert property (@(posedge i_clk) disable iff (!rst_n)
		!tf |-> o_cable_select_oe && o_cable_select_n == ctrl_r[CTL_CABLE_SELECT_N]) else $error("Cable select floating");
	AST_MASTER_SLAVE: assert property (@(posedge i_clk) disable iff (!rst_n)
		tf |-> o_cable_select_oe == !ctrl_r[CTL_CABLE_SELECT_N] && !o_cable_select_n) else $error("Master select wrong");
	AST_PASS_DIAGNOSTIC_N_OFF: assert property (@(posedge i_clk) disable iff (!rst_n)
		!tf |-> !o_pass_diagnostic_oe) else $error("Pass-diagnostic driven outside task-file mode");
	AST_TF_SELECT: assert property (@(posedge i_clk) disable iff (!rst_n)
		tf && sel && !dma_on |-> o_card_enable_n != o_card_enable_odd_n
		&& o_card_enable_odd_n == !ctrl_r[CTL_CBLK]) else $error("Wrong task-file select");
	AST_STATUS_CHANGED_N_EVENT: assert property (@(posedge i_clk) disable iff (!rst_n)
		io_mode && ctrl_r[CTL_STSEN] && $fell(status_changed_n) |=> istat_r[EV_STATUS_CHANGED_N])
		else $error("Status change not recorded");

endmodule : card_host_port

// [card_host_pkg.sv]
// Shared constants and types for the card socket host controller
package card_host_pkg;

	// Clock rate and bus cycle times
	localparam int          CLK_MHZ    = 50;
	localparam int          SETUP_NS   = 30;
	localparam int          STROBE_NS  = 150;
	localparam int          HOLD_NS    = 20;
	// Least times round up to whole cycles
	localparam logic [3:0]  SETUP_CYC  = 4'((SETUP_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0]  STROBE_CYC = 4'((STROBE_NS * CLK_MHZ + 999) / 1000);
	localparam logic [3:0]  HOLD_CYC   = 4'((HOLD_NS * CLK_MHZ + 999) / 1000);

	// Interface modes
	localparam logic [1:0]  MODE_MEM   = 2'h0;
	localparam logic [1:0]  MODE_IO    = 2'h1;
	localparam logic [1:0]  MODE_TF    = 2'h2;

	// Register byte offsets
	localparam logic [7:0]  OFS_CTRL   = 8'h00;
	localparam logic [7:0]  OFS_ADDR   = 8'h04;
	localparam logic [7:0]  OFS_WDATA  = 8'h08;
	localparam logic [7:0]  OFS_RDATA  = 8'h0c;
	localparam logic [7:0]  OFS_CMD    = 8'h10;
	localparam logic [7:0]  OFS_STATUS = 8'h14;
	localparam logic [7:0]  OFS_ISTAT  = 8'h18;
	localparam logic [7:0]  OFS_IMASK  = 8'h1c;

	// Control register fields
	localparam int          CTL_MODE   = 0;
	localparam int          CTL_ATTR   = 2;
	localparam int          CTL_WIDE   = 3;
	localparam int          CTL_DMA    = 4;
	localparam int          CTL_RESET  = 5;
	localparam int          CTL_CABLE_SELECT_N   = 6;
	localparam int          CTL_CBLK   = 7;
	localparam int          CTL_STSEN  = 8;
	localparam int          CTL_PASS_DIAGNOSTIC_N  = 9;
	localparam int          CTL_BITS   = 10;
	localparam logic [9:0]  CTRL_RST   = 10'h000;

	// Command register fields
	localparam int          CMD_GO     = 0;
	localparam int          CMD_WRITE  = 1;
	localparam int          CMD_IO     = 2;

	// Interrupt events
	localparam int          EV_DONE    = 0;
	localparam int          EV_STATUS_CHANGED_N  = 1;
	localparam int          EV_CARDIRQ = 2;
	localparam int          EV_BATT    = 3;
	localparam int          EV_BITS    = 4;

	localparam logic [1:0]  RESP_OKAY  = 2'h0;
	localparam logic [1:0]  RESP_SLV   = 2'h2;

	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_SETUP  = 2'b01,
		ST_STROBE = 2'b10,
		ST_HOLD   = 2'b11
	} cyc_state_type;

endpackage : card_host_pkg

// [card_cycle_engine.sv]
// Timed read/write strobe sequencer for one socket bus cycle
`timescale 1ns/1ps
module card_cycle_engine (
	input  wire logic        i_clk,
	input  wire logic        i_rstn,
	input  wire logic        i_start,
	input  wire logic        i_wait_n,
	input  wire logic [15:0] i_data,
	output logic             o_select,
	output logic             o_strobe,
	output logic             o_busy,
	output logic             o_done,
	output logic [15:0]      o_rdata
);
	import card_host_pkg::*;

	cyc_state_type state_r;
	logic [3:0]    cnt_r;

	assign o_select = (state_r != ST_IDLE);
	assign o_strobe = (state_r == ST_STROBE);
	assign o_busy   = o_select;

	// Phase sequencer; strobe stretches while the card holds wait low
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_r <= ST_IDLE;
			cnt_r   <= 4'h0;
		end else begin
			case (state_r)
				ST_IDLE: begin
					if (i_start) begin
						state_r <= ST_SETUP;
						cnt_r   <= SETUP_CYC - 4'h1;
					end
				end
				ST_SETUP: begin
					if (cnt_r == 4'h0) begin
						state_r <= ST_STROBE;
						cnt_r   <= STROBE_CYC - 4'h1;
					end else cnt_r <= cnt_r - 4'h1;
				end
				ST_STROBE: begin
					if (cnt_r != 4'h0) cnt_r <= cnt_r - 4'h1;
					else if (i_wait_n) begin
						state_r <= ST_HOLD;
						cnt_r   <= HOLD_CYC - 4'h1;
					end
				end
				ST_HOLD: begin
					if (cnt_r == 4'h0) state_r <= ST_IDLE;
					else cnt_r <= cnt_r - 4'h1;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Read data caught at the end of the strobe, done pulse on leaving hold
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= 16'h0000;
			o_done  <= 1'b0;
		end else begin
			if (state_r == ST_STROBE && cnt_r == 4'h0 && i_wait_n) o_rdata <= i_data;
			o_done <= (state_r == ST_HOLD) && (cnt_r == 4'h0);
		end
	end

	sequence s_go;
		i_start && !o_busy;
	endsequence
	sequence s_setup_then_strobe;
		!o_strobe[*2] ##1 o_strobe;
	endsequence

	AST_CYCLE_ORDER: assert property (@(posedge i_clk) disable iff (!i_rstn)
		s_go |=> s_setup_then_strobe) else $error("Strobe did not follow setup");
	AST_STROBE_WIDTH: assert property (@(posedge i_clk) disable iff (!i_rstn)
		$rose(o_strobe) |-> o_strobe[*8]) else $error("Strobe shorter than least width");

endmodule : card_cycle_engine

// [card_model.sv]
// Behavioural card on the far side of the socket pins
`timescale 1ns/1ps
module card_model (
	input  wire logic        i_clk,
	input  wire logic [1:0]  i_mode,
	input  wire logic [10:0] i_addr,
	input  wire logic        i_ce_n,
	input  wire logic        i_ce_odd_n,
	input  wire logic        i_oe_n,
	input  wire logic        i_we_n,
	input  wire logic        i_iord_n,
	input  wire logic        i_iowr_n,
	input  wire logic        i_reg_n,
	input  wire logic [15:0] i_wdata,
	input  wire logic [1:0]  i_wdata_oe,
	input  wire logic        i_host_pass_diagnostic_n,
	input  wire logic        i_status_changed_n_n,
	input  wire logic        i_pass_diagnostic_n_low,
	input  wire logic [7:0]  i_wait_len,
	output logic [15:0]      o_data,
	output logic             o_wait_n,
	output logic             o_pin45,
	output logic             o_pin46
);
	import card_host_pkg::*;
	logic        tf, io, sel, rd, wr;
	logic [5:0]  idx;
	logic [15:0] mem [64];
	logic [15:0] last = 16'h0000;
	logic [7:0]  cnt  = 8'h00;
	// Mode picks the strobe pair; cable select is never sampled
	assign tf  = (i_mode == MODE_TF);
	assign io  = (i_mode == MODE_IO);
	// Upper lines dropped in task-file mode, second select picks the control block
	assign idx = tf ? {2'b10, !i_ce_odd_n, i_addr[2:0]} : {1'b0, i_reg_n, i_addr[3:0]};
	// DMA acknowledge is not looked at when no select is active
	assign sel = !i_ce_n || !i_ce_odd_n;
	assign rd  = sel && ((tf || io) ? !i_iord_n : !i_oe_n);
	assign wr  = sel && ((tf || io) ? !i_iowr_n : !i_we_n);
	// Released bus shows the inverse of the last value, so no stale copy can pass
	assign o_data   = rd ? mem[idx] : ~last;
	assign o_wait_n = !((rd || wr) && cnt < i_wait_len);
	// Battery lines fixed high; line 46 is status change or open-drain diagnostic
	assign o_pin45 = 1'b1;
	assign o_pin46 = tf ? !(i_host_pass_diagnostic_n || i_pass_diagnostic_n_low) : (io ? i_status_changed_n_n : 1'b1);
	// Byte lanes stored only where the host drives them; a floating upper lane is left alone
	always @(posedge i_clk) begin
		last <= o_data;
		cnt  <= (rd || wr) ? cnt + 8'h01 : 8'h00;
		if (wr && i_wdata_oe[0])
			mem[idx][7:0] <= i_wdata[7:0];
		if (wr && i_wdata_oe[1])
			mem[idx][15:8] <= i_wdata[15:8];
	end
endmodule : card_model

// [card_host_port_signal_modes_tb.sv]
// Self-checking bench for the socket host controller
`timescale 1ns/1ps
module card_host_port_signal_modes_tb;
	import card_host_pkg::*;
	logic        i_clk = 0, i_rstn = 0;
	logic [7:0]  awaddr = 0, araddr = 0, wait_len = 0;
	logic [31:0] wdata = 0, rv, ctrl_v = 0;
	logic [3:0]  wstrb = 0;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic        pin37 = 1, status_changed_n_n = 1, pass_diagnostic_n_low = 0, hi_seen = 0, sel_seen = 0;
	logic        awready, wready, bvalid, arready, rvalid, irq, ce_n, ce_odd_n, oe_n, we_n, iord_n, iowr_n;
	logic        reg_n, card_reset, cable_select_n_n, cable_select_n_oe, pd_n, pd_oe, wait_n, pin45, pin46;
	logic [1:0]  bresp, rresp, resp, data_oe;
	logic [31:0] rdata;
	logic [10:0] addr;
	logic [15:0] hdata, cdata;
	int          n_fail = 0, comparisons = 0, strobes = 0;

	card_host_port i_card_host_port (.i_clk(i_clk), .i_rstn(i_rstn), .i_awaddr(awaddr), .i_awvalid(awvalid),
		.o_awready(awready), .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
		.o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid), .i_rready(rready),
		.o_irq(irq), .o_addr(addr), .o_card_enable_n(ce_n), .o_card_enable_odd_n(ce_odd_n), .o_oe_n(oe_n),
		.o_we_n(we_n), .o_iord_n(iord_n), .o_iowr_n(iowr_n), .o_reg_n(reg_n), .o_card_reset(card_reset),
		.o_cable_select_n(cable_select_n_n), .o_cable_select_oe(cable_select_n_oe), .o_data(hdata), .o_data_oe(data_oe),
		.i_data(cdata), .i_ready_irq(pin37), .i_wait_n(wait_n), .i_battery_detect_second(pin45),
		.i_shared_status(pin46), .o_pass_diagnostic_n(pd_n), .o_pass_diagnostic_oe(pd_oe));
	card_model i_card_model (.i_clk(i_clk), .i_mode(ctrl_v[1:0]), .i_addr(addr), .i_ce_n(ce_n),
		.i_ce_odd_n(ce_odd_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_iord_n(iord_n), .i_iowr_n(iowr_n),
		.i_reg_n(reg_n), .i_wdata(hdata), .i_wdata_oe(data_oe), .i_host_pass_diagnostic_n(pd_oe && !pd_n),
		.i_status_changed_n_n(status_changed_n_n), .i_pass_diagnostic_n_low(pass_diagnostic_n_low), .i_wait_len(wait_len), .o_data(cdata),
		.o_wait_n(wait_n), .o_pin45(pin45), .o_pin46(pin46));

	initial forever #10 i_clk = ~i_clk;
	// Watches socket activity on every clock, commands included: upper lane, selects, strobe length
	always @(posedge i_clk) begin
		if (data_oe[1] || !ce_odd_n)
			hi_seen <= 1;
		if (!ce_n || !ce_odd_n)
			sel_seen <= 1;
		if (!we_n || !iord_n || !iowr_n || (!oe_n && ctrl_v[1:0] != MODE_TF))
			strobes <= strobes + 1;
	end

	task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check

	task stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask : stop_test

	// Address and data offered together, each dropped once taken
	task axw(input logic [7:0] a, input logic [31:0] d);
		logic ad, wd, ah, wh;
		ad = 0;
		wd = 0;
		@(posedge i_clk);
		awaddr <= a;
		wdata <= d;
		wstrb <= 4'hf;
		awvalid <= 1;
		wvalid <= 1;
		while (!(ad && wd)) begin
			@(negedge i_clk);
			ah = awvalid && (awready === 1'b1);
			wh = wvalid && (wready === 1'b1);
			@(posedge i_clk);
			awvalid <= awvalid && !ah;
			wvalid <= wvalid && !wh;
			ad = ad || ah;
			wd = wd || wh;
		end
		bready <= 1;
		do @(negedge i_clk); while (bvalid !== 1'b1);
		resp = bresp;
		@(posedge i_clk);
		bready <= 0;
	endtask : axw

	task axr(input logic [7:0] a);
		@(posedge i_clk);
		araddr <= a;
		arvalid <= 1;
		do @(negedge i_clk); while (arready !== 1'b1);
		@(posedge i_clk);
		arvalid <= 0;
		rready <= 1;
		do @(negedge i_clk); while (rvalid !== 1'b1);
		resp = rresp;
		rv = rdata;
		@(posedge i_clk);
		rready <= 0;
	endtask : axr

	task setc(input logic [31:0] c);
		ctrl_v = c;
		axw(OFS_CTRL, c);
	endtask : setc

	// Starts a socket cycle, polls the done event and clears it
	task cmd(input logic [2:0] c);
		axw(OFS_CMD, {29'h0, c});
		rv = 0;
		for (int i = 0; i < 40 && rv[EV_DONE] !== 1'b1; i++)
			axr(OFS_ISTAT);
		check("cycle done", rv[EV_DONE], 1);
		axw(OFS_ISTAT, 32'h1);
	endtask : cmd

	task xfer(input logic [31:0] ct, input logic [10:0] a, input logic [15:0] d, input logic [2:0] c);
		setc(ct);
		axw(OFS_ADDR, {21'h0, a});
		axw(OFS_WDATA, {16'h0, d});
		cmd(c);
		if (!c[CMD_WRITE])
			axr(OFS_RDATA);
	endtask : xfer

	task t_reset;
		axr(OFS_CTRL);
		check("ctrl reset", rv, 0);
		axr(OFS_IMASK);
		check("imask reset", rv, 0);
		axr(8'h40);
		check("unmapped resp", resp, RESP_SLV);
		axw(OFS_RDATA, 32'h1);
		check("read-only resp", resp, RESP_SLV);
		check("enable idle", ce_n, 1);
		check("irq idle", irq, 0);
		check("card reset idle", card_reset, 0);
		$display("test reset done");
	endtask : t_reset

	// CTRL bits: 4 attribute, 8 wide, 40 cable select, 80 control block, 100 status enable, 200 diagnostic
	task t_mem;
		xfer(32'h4c, 11'h003, 16'h1234, 3'b011);
		check("attribute pin", reg_n, 0);
		check("cable select", {cable_select_n_oe, cable_select_n_n}, 2'b11);
		xfer(32'h08, 11'h003, 16'h5678, 3'b011);
		xfer(32'h0c, 11'h003, 16'h0000, 3'b001);
		check("attribute read", rv[15:0], 16'h1234);
		xfer(32'h08, 11'h003, 16'h0000, 3'b001);
		check("common read", rv[15:0], 16'h5678);
		axr(OFS_STATUS);
		check("battery lines", rv[3:2], 2'b11);
		axr(OFS_ISTAT);
		check("battery event", rv[EV_BATT], 0);
		xfer(32'h08, 11'h004, 16'h9999, 3'b011);
		hi_seen = 0;
		xfer(32'h00, 11'h004, 16'habcd, 3'b011);
		check("upper lane idle", hi_seen, 0);
		xfer(32'h08, 11'h004, 16'h0000, 3'b001);
		check("byte write", rv[15:0], 16'h99cd);
		$display("test memory mode done");
	endtask : t_mem

	task t_io;
		wait_len <= 12;
		strobes = 0;
		xfer(32'h09, 11'h003, 16'h0000, 3'b101);
		check("io decode", rv[15:0], 16'h5678);
		check("wait stretch", strobes >= 12, 1);
		wait_len <= 0;
		pin37 <= 0;
		axr(OFS_STATUS);
		check("ready pin", rv[1], 0);
		pin37 <= 1;
		$display("test io mode done");
	endtask : t_io

	task t_tf;
		setc(32'h0a);
		axw(OFS_ADDR, 32'h7fd);
		check("tf address", addr, 11'h005);
		check("dma ack idle", reg_n, 1);
		check("master select", {cable_select_n_oe, cable_select_n_n}, 2'b10);
		check("tf reset pin", card_reset, 1);
		setc(32'h4a);
		check("slave select", cable_select_n_oe, 0);
		xfer(32'h0a, 11'h7fd, 16'h1111, 3'b011);
		xfer(32'h8a, 11'h005, 16'h2222, 3'b011);
		xfer(32'h0a, 11'h005, 16'h0000, 3'b001);
		check("task file reg", rv[15:0], 16'h1111);
		xfer(32'h8a, 11'h7fd, 16'h0000, 3'b001);
		check("control reg", rv[15:0], 16'h2222);
		setc(32'h20a);
		check("diag drive", pd_oe, 1);
		axr(OFS_STATUS);
		check("diag low", rv[2], 0);
		setc(32'h0a);
		axr(OFS_STATUS);
		check("diag released", rv[2], 1);
		pass_diagnostic_n_low <= 1;
		axr(OFS_STATUS);
		check("diag from card", rv[2], 0);
		pass_diagnostic_n_low <= 0;
		setc(32'h1a);
		sel_seen = 0;
		hi_seen = 0;
		cmd(3'b011);
		check("dma selects", sel_seen, 0);
		check("dma width", hi_seen, 1);
		$display("test task-file mode done");
	endtask : t_tf

	task t_irq;
		setc(32'h101);
		axw(OFS_IMASK, 32'h2);
		axw(OFS_ISTAT, 32'hf);
		status_changed_n_n <= 0;
		repeat (3) @(posedge i_clk);
		status_changed_n_n <= 1;
		axr(OFS_ISTAT);
		check("status change", rv[EV_STATUS_CHANGED_N], 1);
		check("irq raised", irq, 1);
		axw(OFS_IMASK, 32'h0);
		check("irq masked", irq, 0);
		axw(OFS_IMASK, 32'h2);
		axw(OFS_ISTAT, 32'h2);
		check("irq cleared", irq, 0);
		setc(32'h01);
		status_changed_n_n <= 0;
		repeat (3) @(posedge i_clk);
		status_changed_n_n <= 1;
		axr(OFS_ISTAT);
		check("change disabled", rv[EV_STATUS_CHANGED_N], 0);
		$display("test status change done");
	endtask : t_irq

	initial begin
		repeat (20) @(posedge i_clk);
		i_rstn <= 1;
		repeat (3) @(posedge i_clk);
		t_reset;
		t_mem;
		t_io;
		t_tf;
		t_irq;
		stop_test;
	end
	// A hung handshake ends the run as a failure
	initial begin
		#800000;
		n_fail++;
		stop_test;
	end
endmodule : card_host_port_signal_modes_tb
